// ### logic/vtpg_pkg.sv
/*
  Package for the video test pattern generator: register map, field positions,
  reset values, indirect-map layout and generator constants.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package vtpg_pkg;

  // ----------------------------------------
  // register map (printed offsets are register indexes)
  // ----------------------------------------
  localparam logic [7:0] VTPG_IDX_CONTROL = 8'h64;  // pattern_control, index chosen
  localparam logic [7:0] VTPG_IDX_CONFIG = 8'h65;
  localparam logic [7:0] VTPG_IDX_IADDR = 8'h66;
  localparam logic [7:0] VTPG_IDX_IDATA = 8'h67;
  localparam logic [7:0] VTPG_IDX_STATUS = 8'h6A;   // own status register
  localparam int VTPG_ADDR_W = 12;
  localparam int VTPG_WORD_SHIFT = 2;

  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int VTPG_CTL_EN = 0;
  localparam int VTPG_CTL_SEL_LO = 4;
  localparam int VTPG_CFG_ASCRL = 0;
  localparam int VTPG_CFG_INV = 1;
  localparam int VTPG_CFG_TSEL = 2;
  localparam int VTPG_CFG_EXTCLK = 3;
  localparam int VTPG_CFG_18B = 4;
  localparam logic [7:0] VTPG_CFG_MASK = 8'h1F;     // bits 7-5 reserved, read zero
  localparam logic [7:0] VTPG_CTL_RESET = 8'h10;    // fixed pattern 1 after reset
  localparam logic [7:0] VTPG_REG_RESET = 8'h00;

  // ----------------------------------------
  // indirect map
  // ----------------------------------------
  localparam int VTPG_IND_DEPTH = 16;
  localparam logic [7:0] VTPG_IND_FRAME_TIME = 8'h00;  // frame_time_setting
  localparam logic [7:0] VTPG_IND_HACT = 8'h01;        // active width, units of 8 px
  localparam logic [7:0] VTPG_IND_HTOT = 8'h02;        // total width, units of 8 px
  localparam logic [7:0] VTPG_IND_VACT = 8'h03;        // active lines, units of 8
  localparam logic [7:0] VTPG_IND_VTOT = 8'h04;        // total lines, units of 8
  localparam logic [7:0] VTPG_IND_HSW = 8'h05;
  localparam logic [7:0] VTPG_IND_VSW = 8'h06;
  localparam int VTPG_SIZE_SHIFT = 3;

  // ----------------------------------------
  // patterns, bus responses and bus states
  // ----------------------------------------
  localparam logic [3:0] VTPG_PAT_FIRST = 4'h1;
  localparam logic [3:0] VTPG_PAT_LAST = 4'hD;
  localparam logic [1:0] VTPG_AXI_OKAY = 2'h0;
  localparam logic [1:0] VTPG_AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    VTPG_BUS_IDLE = 2'b00,
    VTPG_BUS_WRESP = 2'b01,
    VTPG_BUS_RRESP = 2'b10
  } vtpg_bus_state_t;

endpackage : vtpg_pkg

// ### logic/vtpg_cfg_if.sv
/*
  Interface carrying generator settings from the register file to the pixel engine.
  Assumes both ends run on the same clock.
*/
interface vtpg_cfg_if;
  logic enable;
  logic depth18;
  logic ext_clock;
  logic own_timing;
  logic invert;
  logic scroll;
  logic [3:0] fixed_sel;
  logic [7:0] frame_time;
  logic [7:0] hact;
  logic [7:0] htot;
  logic [7:0] vact;
  logic [7:0] vtot;
  logic [7:0] hsw;
  logic [7:0] vsw;
  logic [3:0] cur_pattern;
  modport regs (output enable, depth18, ext_clock, own_timing, invert, scroll, fixed_sel,
                frame_time, hact, htot, vact, vtot, hsw, vsw, input cur_pattern);
  modport engine (input enable, depth18, ext_clock, own_timing, invert, scroll, fixed_sel,
                  frame_time, hact, htot, vact, vtot, hsw, vsw, output cur_pattern);
endinterface : vtpg_cfg_if

// ### logic/vtpg_engine.sv
/*
  Pixel engine: timing (own or external), pattern choice, scrolling, colour.
  Assumes external video inputs are synchronous to aclk; div_tick is the
  internally divided pixel rate.
*/
module vtpg_engine
  import vtpg_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  vtpg_cfg_if.engine cfg,
  // pixel rate qualifiers
  input wire logic ext_pclk_tick,
  input wire logic div_tick,
  // external timing
  input wire logic ext_de,
  input wire logic ext_hs,
  input wire logic ext_vs,
  // video out
  output logic [23:0] rgb,
  output logic de,
  output logic hs,
  output logic vs
);

  typedef struct packed {
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    logic [7:0] frames;
    logic [3:0] pattern;
    logic ext_de_d;
    logic [7:0] level;
    logic [23:0] rgb;
    logic de;
    logic hs;
    logic vs;
  } vtpg_eng_t;

  vtpg_eng_t r;
  vtpg_eng_t next_r;

  // scaled brightness from position against active span
  function automatic logic [7:0] vtpg_scale(input logic [11:0] pos, input logic [7:0] span8);
    logic [19:0] prod;
    logic [11:0] span;
    prod = {pos, 8'h00};
    span = {1'b0, span8, 3'b000};
    if (span == 12'h000) begin
      vtpg_scale = 8'h00;
    end else begin
      vtpg_scale = 8'(prod / {8'h00, span});
    end
  endfunction : vtpg_scale

  logic tick;
  logic frame_end;
  logic [11:0] hact_px;
  logic [11:0] htot_px;
  logic [11:0] vact_ln;
  logic [11:0] vtot_ln;
  logic [7:0] lvl;
  logic [23:0] color;
  logic act;

  // pixel rate: clock source matters only under own timing
  assign tick = cfg.own_timing ? (cfg.ext_clock ? ext_pclk_tick : div_tick) : ext_pclk_tick;
  assign hact_px = 12'({cfg.hact, 3'b000});
  assign htot_px = 12'({cfg.htot, 3'b000});
  assign vact_ln = 12'({cfg.vact, 3'b000});
  assign vtot_ln = 12'({cfg.vtot, 3'b000});
  assign cfg.cur_pattern = r.pattern;

  always_comb begin
    next_r = r;
    frame_end = 1'b0;
    act = 1'b0;
    lvl = 8'h00;
    color = 24'h000000;
    if (tick) begin
      // timing counters
      if (cfg.own_timing) begin
        act = (r.hcnt < hact_px) && (r.vcnt < vact_ln);
        next_r.hs = r.hcnt >= (htot_px - 12'({4'h0, cfg.hsw}));
        next_r.vs = r.vcnt < 12'({4'h0, cfg.vsw});
        if (r.hcnt + 12'h001 >= htot_px) begin
          next_r.hcnt = 12'h000;
          if (r.vcnt + 12'h001 >= vtot_ln) begin
            next_r.vcnt = 12'h000;
            frame_end = 1'b1;
          end else begin
            next_r.vcnt = r.vcnt + 12'h001;
          end
        end else begin
          next_r.hcnt = r.hcnt + 12'h001;
        end
      end else begin
        act = ext_de;
        next_r.hs = ext_hs;
        next_r.vs = ext_vs;
        next_r.ext_de_d = ext_de;
        if (ext_de) begin
          next_r.hcnt = r.hcnt + 12'h001;
        end else begin
          next_r.hcnt = 12'h000;
        end
        if (r.ext_de_d && !ext_de) begin
          next_r.vcnt = r.vcnt + 12'h001;
        end
        if (ext_vs) begin
          if (r.vcnt != 12'h000) begin
            frame_end = 1'b1;
          end
          next_r.vcnt = 12'h000;
        end
      end
      // brightness ramp; 18-bit keeps only six top bits
      if (r.pattern >= 4'hA) begin
        lvl = vtpg_scale(r.vcnt, cfg.vact);
      end else begin
        lvl = vtpg_scale(r.hcnt, cfg.hact);
      end
      if (cfg.depth18) begin
        lvl = {lvl[7:2], 2'b00};
      end
      case (r.pattern)
        4'h1: color = 24'hFFFFFF;
        4'h2: color = 24'h000000;
        4'h3: color = 24'hFF0000;
        4'h4: color = 24'h00FF00;
        4'h5: color = 24'h0000FF;
        4'h6, 4'hA: color = {lvl, lvl, lvl};
        4'h7, 4'hB: color = {lvl, 8'h00, 8'h00};
        4'h8, 4'hC: color = {8'h00, lvl, 8'h00};
        4'h9, 4'hD: color = {8'h00, 8'h00, lvl};
        default: color = 24'h000000;
      endcase
      if (cfg.invert) begin
        color = ~color;
      end
      if (cfg.depth18) begin
        color = color & 24'hFCFCFC;
      end
      next_r.de = act;
      next_r.rgb = act ? color : 24'h000000;
      // scrolling after frame_time frames
      if (frame_end && cfg.scroll) begin
        if (r.frames + 8'h01 >= cfg.frame_time) begin
          next_r.frames = 8'h00;
          next_r.pattern = (r.pattern >= VTPG_PAT_LAST) ? VTPG_PAT_FIRST : r.pattern + 4'h1;
        end else begin
          next_r.frames = r.frames + 8'h01;
        end
      end
    end
    // fixed pattern holds while scrolling is off; ignored while on
    if (!cfg.scroll) begin
      next_r.pattern = cfg.fixed_sel;
      next_r.frames = 8'h00;
    end
    // disabled generator drives nothing
    if (!cfg.enable) begin
      next_r.rgb = 24'h000000;
      next_r.de = 1'b0;
      next_r.hs = 1'b0;
      next_r.vs = 1'b0;
      next_r.hcnt = 12'h000;
      next_r.vcnt = 12'h000;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rgb = r.rgb;
  assign de = r.de;
  assign hs = r.hs;
  assign vs = r.vs;

endmodule : vtpg_engine

// ### logic/vtpg_top.sv
/*
  Video test pattern generator: AXI4-Lite register file with indirect access,
  driving the pixel engine toward the display output path.
  Assumes an AXI4-Lite master on aclk and synchronous external video inputs.
*/
module vtpg_top
  import vtpg_pkg::*;
#(
  parameter int DIV_RATIO = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [VTPG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [VTPG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external video timing
  input wire logic ext_pclk_tick,
  input wire logic ext_de,
  input wire logic ext_hs,
  input wire logic ext_vs,
  // generated video
  output logic [23:0] video_rgb,
  output logic video_de,
  output logic video_hs,
  output logic video_vs
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    vtpg_bus_state_t bus;
    logic aw_held;
    logic w_held;
    logic [VTPG_ADDR_W-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] control;
    logic [7:0] config_r;
    logic [7:0] iaddr;
    logic [7:0] div_cnt;
    logic div_tick;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
  } vtpg_top_t;

  vtpg_top_t r;
  vtpg_top_t next_r;
  logic [7:0] ind_mem [VTPG_IND_DEPTH];
  logic ind_we;
  logic [7:0] ind_rd;
  logic [23:0] eng_rgb;
  logic eng_de;
  logic eng_hs;
  logic eng_vs;
  logic [23:0] rgb_q;
  logic de_q;
  logic hs_q;
  logic vs_q;

  vtpg_cfg_if cfg_if ();

  // word index from byte address, decoded for both channels
  function automatic logic [7:0] vtpg_index(input logic [VTPG_ADDR_W-1:0] a);
    vtpg_index = a[VTPG_WORD_SHIFT +: 8];
  endfunction : vtpg_index

  function automatic logic vtpg_mapped(input logic [VTPG_ADDR_W-1:0] a);
    logic [7:0] i;
    i = vtpg_index(a);
    vtpg_mapped = (a[VTPG_ADDR_W-1 -: 2] == 2'b00) &&
                  (i == VTPG_IDX_CONTROL || i == VTPG_IDX_CONFIG || i == VTPG_IDX_IADDR ||
                   i == VTPG_IDX_IDATA || i == VTPG_IDX_STATUS);
  endfunction : vtpg_mapped

  // indirect slot selected by the indirect address
  function automatic logic vtpg_ind_hit(input logic [7:0] ia);
    vtpg_ind_hit = ia < 8'(VTPG_IND_DEPTH);
  endfunction : vtpg_ind_hit

  // ----------------------------------------
  // register file and bus slave
  // ----------------------------------------
  // writes complete only when address and data are both held, in any order
  always_comb begin
    next_r = r;
    ind_we = 1'b0;
    ind_rd = vtpg_ind_hit(r.iaddr) ? ind_mem[r.iaddr[3:0]] : 8'h00;
    // divided clock tick for own timing
    if (r.div_cnt + 8'h01 >= 8'(DIV_RATIO)) begin
      next_r.div_cnt = 8'h00;
      next_r.div_tick = 1'b1;
    end else begin
      next_r.div_cnt = r.div_cnt + 8'h01;
      next_r.div_tick = 1'b0;
    end
    case (r.bus)
      VTPG_BUS_IDLE: begin
        if (s_axi_awvalid && !r.aw_held) begin
          next_r.aw_held = 1'b1;
          next_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_held) begin
          next_r.w_held = 1'b1;
          next_r.wbyte = s_axi_wdata[7:0];
          next_r.wlane = s_axi_wstrb[0];
        end
        if (r.aw_held && r.w_held) begin
          next_r.aw_held = 1'b0;
          next_r.w_held = 1'b0;
          next_r.bus = VTPG_BUS_WRESP;
          next_r.bresp = vtpg_mapped(r.awaddr) ? VTPG_AXI_OKAY : VTPG_AXI_SLVERR;
          if (r.wlane && vtpg_mapped(r.awaddr)) begin
            case (vtpg_index(r.awaddr))
              VTPG_IDX_CONTROL: next_r.control = r.wbyte;
              VTPG_IDX_CONFIG: next_r.config_r = r.wbyte & VTPG_CFG_MASK;
              VTPG_IDX_IADDR: next_r.iaddr = r.wbyte;
              VTPG_IDX_IDATA: ind_we = vtpg_mapped(r.awaddr) && vtpg_ind_hit(r.iaddr);
              default: ;
            endcase
          end
        end else if (s_axi_arvalid && !r.aw_held && !r.w_held) begin
          next_r.bus = VTPG_BUS_RRESP;
          next_r.rresp = vtpg_mapped(s_axi_araddr) ? VTPG_AXI_OKAY : VTPG_AXI_SLVERR;
          case (vtpg_index(s_axi_araddr))
            VTPG_IDX_CONTROL: next_r.rdata = {24'h000000, r.control};
            VTPG_IDX_CONFIG: next_r.rdata = {24'h000000, r.config_r};
            VTPG_IDX_IADDR: next_r.rdata = {24'h000000, r.iaddr};
            VTPG_IDX_IDATA: next_r.rdata = {24'h000000, ind_rd};
            VTPG_IDX_STATUS: next_r.rdata = {28'h0000000, cfg_if.cur_pattern};
            default: next_r.rdata = 32'h00000000;
          endcase
          if (!vtpg_mapped(s_axi_araddr)) begin
            next_r.rdata = 32'h00000000;
          end
        end
      end
      VTPG_BUS_WRESP: begin
        if (s_axi_bready) begin
          next_r.bus = VTPG_BUS_IDLE;
        end
      end
      VTPG_BUS_RRESP: begin
        if (s_axi_rready) begin
          next_r.bus = VTPG_BUS_IDLE;
        end
      end
      default: next_r.bus = VTPG_BUS_IDLE;
    endcase
    // handshake flags registered, so the bus sees flip-flops only
    next_r.awready = (next_r.bus == VTPG_BUS_IDLE) && !next_r.aw_held;
    next_r.wready = (next_r.bus == VTPG_BUS_IDLE) && !next_r.w_held;
    next_r.arready = (next_r.bus == VTPG_BUS_IDLE) && !next_r.aw_held && !next_r.w_held;
    next_r.bvalid = (next_r.bus == VTPG_BUS_WRESP);
    next_r.rvalid = (next_r.bus == VTPG_BUS_RRESP);
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.control <= VTPG_CTL_RESET;
      r.config_r <= VTPG_REG_RESET;
      r.iaddr <= VTPG_REG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // indirect array, one byte per slot; reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < VTPG_IND_DEPTH; i++) begin
        ind_mem[i] <= VTPG_REG_RESET;
      end
    end else if (ind_we) begin
      ind_mem[r.iaddr[3:0]] <= r.wbyte;
    end
  end

  // ----------------------------------------
  // settings to the engine
  // ----------------------------------------
  assign cfg_if.enable = r.control[VTPG_CTL_EN];
  assign cfg_if.fixed_sel = r.control[VTPG_CTL_SEL_LO +: 4];
  assign cfg_if.depth18 = r.config_r[VTPG_CFG_18B];
  assign cfg_if.ext_clock = r.config_r[VTPG_CFG_EXTCLK];
  assign cfg_if.own_timing = r.config_r[VTPG_CFG_TSEL];
  assign cfg_if.invert = r.config_r[VTPG_CFG_INV];
  assign cfg_if.scroll = r.config_r[VTPG_CFG_ASCRL];
  assign cfg_if.frame_time = ind_mem[VTPG_IND_FRAME_TIME[3:0]];
  assign cfg_if.hact = ind_mem[VTPG_IND_HACT[3:0]];
  assign cfg_if.htot = ind_mem[VTPG_IND_HTOT[3:0]];
  assign cfg_if.vact = ind_mem[VTPG_IND_VACT[3:0]];
  assign cfg_if.vtot = ind_mem[VTPG_IND_VTOT[3:0]];
  assign cfg_if.hsw = ind_mem[VTPG_IND_HSW[3:0]];
  assign cfg_if.vsw = ind_mem[VTPG_IND_VSW[3:0]];

  vtpg_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg_if.engine),
    .ext_pclk_tick(ext_pclk_tick),
    .div_tick(r.div_tick),
    .ext_de(ext_de),
    .ext_hs(ext_hs),
    .ext_vs(ext_vs),
    .rgb(eng_rgb),
    .de(eng_de),
    .hs(eng_hs),
    .vs(eng_vs)
  );

  // output stage; also keeps engine outputs one cycle behind for timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rgb_q <= 24'h000000;
      de_q <= 1'b0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      rgb_q <= eng_rgb;
      de_q <= eng_de;
      hs_q <= eng_hs;
      vs_q <= eng_vs;
    end
  end

  // ----------------------------------------
  // bus and video outputs
  // ----------------------------------------
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign video_rgb = rgb_q;
  assign video_de = de_q;
  assign video_hs = hs_q;
  assign video_vs = vs_q;

endmodule : vtpg_top

// ### verif/vtpg_checker.sv
/*
  Bus and output relations of the pattern generator top, seen at its ports only.
  Assumes a single aclk domain with synchronous active-low aresetn.
*/
module vtpg_checker
  import vtpg_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // video
  input wire logic [23:0] video_rgb,
  input wire logic video_de
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // response timing and holding
  // ----------------------------------------
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not on time");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  // one transfer of each kind at a time
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_write_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  // ----------------------------------------
  // read data contents
  // ----------------------------------------
  a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == VTPG_AXI_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_data_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // generator quiet straight after reset
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !video_de && video_rgb == 24'h0)
    else $error("outputs busy after reset");

  c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == VTPG_AXI_OKAY);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == VTPG_AXI_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_video: cover property ($rose(video_de));
endmodule : vtpg_checker

bind vtpg_top vtpg_checker u_checker (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .video_rgb(video_rgb), .video_de(video_de));

// ### verif/vtpg_display_sink.sv
/*
  Display output path model: counts active-region starts of the video stream.
  Assumes video outputs are registered on aclk.
*/
module vtpg_display_sink (
  // clock
  input wire logic aclk,
  // video in
  input wire logic video_de,
  // observation
  output int rises
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev = 1'b0;
  // a display latches one line per enable rise
  always @(posedge aclk) begin
    if (video_de && !prev) rises <= rises + 1;
    prev <= video_de;
  end
  initial rises = 0;
endmodule : vtpg_display_sink

// ### verif/video_test_pattern_generator_bench.sv
/*
  Self-checking bench: registers over AXI4-Lite, indirect map, colours, scrolling, timing.
  Assumes the top on aclk at 100 MHz and the display sink as far side.
*/
module video_test_pattern_generator_bench
  import vtpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] A_CTL = {2'b0, VTPG_IDX_CONTROL, 2'b0};
  localparam logic [11:0] A_CFG = {2'b0, VTPG_IDX_CONFIG, 2'b0};
  localparam logic [11:0] A_IA = {2'b0, VTPG_IDX_IADDR, 2'b0};
  localparam logic [11:0] A_ID = {2'b0, VTPG_IDX_IDATA, 2'b0};
  localparam logic [11:0] A_ST = {2'b0, VTPG_IDX_STATUS, 2'b0};
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_pclk_tick = 1, tick_mode = 0, ext_de = 0, ext_hs = 0, ext_vs = 0;
  logic [23:0] video_rgb;
  logic video_de, video_hs, video_vs;
  int miscompares = 0, compares = 0, seed = 32'h431496c4, rises, r;
  logic [7:0] mem [16];

  vtpg_top #(.DIV_RATIO(4)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_pclk_tick, .ext_de, .ext_hs, .ext_vs, .video_rgb, .video_de, .video_hs, .video_vs);
  vtpg_display_sink u_sink (.aclk, .video_de, .rises);

  // ----------------------------------------
  // clock, pixel qualifier, watchdog
  // ----------------------------------------
  always #5 aclk = ~aclk;
  // every cycle, or every other cycle for a slower external pixel clock
  always @(posedge aclk) ext_pclk_tick <= tick_mode ? ~ext_pclk_tick : 1'b1;
  initial begin
    #300000;
    miscompares++;
    results();
  end

  task automatic results();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one write; upper data bits random since only lane 0 counts
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = VTPG_AXI_OKAY);
    logic [31:0] w;
    w = $random(seed);
    w[7:0] = d;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1'($random(seed));
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = VTPG_AXI_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1'($random(seed));
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 0;
    chk(s_axi_rdata, {24'h0, e});
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd

  // indirect write always preceded by its address
  task automatic ind(input logic [7:0] a, input logic [7:0] d);
    wr(A_IA, a);
    wr(A_ID, d);
  endtask : ind

  function automatic logic [23:0] exp_rgb(input logic [3:0] p, input logic inv, input logic d18);
    logic [23:0] c;
    case (p)
      4'h1: c = 24'hFFFFFF;
      4'h3: c = 24'hFF0000;
      4'h4: c = 24'h00FF00;
      4'h5: c = 24'h0000FF;
      default: c = 24'h000000;
    endcase
    if (inv) c = ~c;
    if (d18) c = c & 24'hFCFCFC;
    return c;
  endfunction : exp_rgb

  // external timing; compare de, hs and vs only where inputs stood still long enough to ride out the pipeline
  task automatic vcheck(input logic en, input logic [3:0] p, input logic inv, input logic d18, input logic xclk);
    logic [14:0] h;
    logic [2:0] cur;
    h = 0;
    cur = 0;
    wr(A_CFG, {3'b0, d18, xclk, 1'b0, inv, 1'b0});
    wr(A_CTL, {p, 3'b0, en});
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (i % 4 == 0) cur = 3'($random(seed));
      {ext_de, ext_hs, ext_vs} <= cur;
      h = {h[11:0], cur};
      if (i >= 5 && h[8:6] == h[11:9] && h[11:9] == h[14:12]) chk({video_de, video_hs, video_vs}, en ? h[11:9] : 3'b0);
      if (en && video_de) chk(video_rgb, exp_rgb(p, inv, d18));
    end
    {ext_de, ext_hs, ext_vs} <= 3'b0;
  endtask : vcheck

  task automatic frame();
    for (int i = 0; i < 30; i++) begin
      @(posedge aclk);
      ext_de <= (i < 8);
      ext_vs <= (i >= 12 && i < 16);
    end
  endtask : frame

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(A_CTL, VTPG_CTL_RESET);
    rd(A_CFG, 8'h00);
    rd(A_IA, 8'h00);
    rd(A_ID, 8'h00);
    wr(A_CFG, 8'hFF);
    rd(A_CFG, VTPG_CFG_MASK);
    wr(12'h18C, 8'h01, VTPG_AXI_SLVERR);
    rd(12'h400, 8'h00, VTPG_AXI_SLVERR);
    wr(A_IA, 8'hA7);
    rd(A_IA, 8'hA7);
    ind(8'h20, 8'h55);
    rd(A_ID, 8'h00);
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'($random(seed));
      ind(i[7:0], mem[i]);
    end
    for (int i = 15; i >= 0; i--) begin
      wr(A_IA, i[7:0]);
      rd(A_ID, mem[i]);
    end
    vcheck(0, 4'h1, 0, 0, 0);
    for (int p = 1; p <= 5; p++) for (int m = 0; m < 4; m++) vcheck(1, p[3:0], m[0], m[1], 1'($random(seed)));
    // scrolling from pattern 3, one frame per pattern
    ind(VTPG_IND_FRAME_TIME, 8'h01);
    wr(A_CTL, 8'h31);
    wr(A_CFG, 8'h01);
    rd(A_ST, 8'h03);
    wr(A_CTL, 8'h91);
    rd(A_ST, 8'h03);
    frame();
    rd(A_ST, 8'h04);
    wr(A_CFG, 8'h00);
    rd(A_ST, 8'h09);
    frame();
    frame();
    rd(A_ST, 8'h09);
    // own timing: 16x16 total, 8x8 active, divided clock of 4 gives 1024 cycles a frame
    ind(VTPG_IND_HACT, 8'h01);
    ind(VTPG_IND_HTOT, 8'h02);
    ind(VTPG_IND_VACT, 8'h01);
    ind(VTPG_IND_VTOT, 8'h02);
    ind(VTPG_IND_HSW, 8'h01);
    ind(VTPG_IND_VSW, 8'h01);
    wr(A_CFG, 8'h04);
    wr(A_CTL, 8'h11);
    repeat (2100) @(posedge aclk);
    r = rises;
    repeat (1024) @(posedge aclk);
    chk(rises - r, 8);
    tick_mode <= 1;
    wr(A_CFG, 8'h0C);
    repeat (1100) @(posedge aclk);
    r = rises;
    repeat (512) @(posedge aclk);
    chk(rises - r, 8);
    results();
  end
endmodule : video_test_pattern_generator_bench
